// ===== logic/abi_pkg.sv
// Shared constants, register map and state encodings of the accelerator block interface.
// Operation
// RULE_01 - Controller raises start; core drops idle while a transaction runs.
// RULE_02 - Core raises ready once every input of the transaction is consumed.
// RULE_03 - Core raises done on completion, marking the result output valid.
// RULE_04 - After completion and until a new start, idle stays high.
// RULE_05 - Start/ready/done/idle handshake is the default block-level control mode.
// RULE_06 - Chained mode: continue low at completion halts until continue goes high.
// RULE_07 - No-control mode shows no start, ready, done, idle or continue activity.
// RULE_08 - Register-mapped control reaches start, done, idle and continue through registers.
// RULE_09 - A streaming port carries read-only or write-only arguments, never both.
// RULE_10 - Register interface carries scalar arguments; several share one register block.
// RULE_11 - Plain and stable wire modes are bare data ports; plain is scalar default.
// RULE_12 - Outside party changes stable configuration inputs only while core is in reset.
// RULE_13 - Full handshake mode pairs data with valid and acknowledge.
// RULE_14 - Valid-only mode adds only valid; acknowledge-only adds only acknowledge.
// RULE_15 - Read-write argument splits into plain input and output with valid.
// RULE_16 - Full handshake on arrays only for strictly sequential access order.
// RULE_17 - Arrays default to a memory port with data, address, enable, write enable.
// RULE_18 - Grouped memory mode equals memory port mode at the signal level.
// RULE_19 - A FIFO port serves sequential arrays, either reading or writing, not both.
// RULE_20 - Bus bridge arbitrates the system bus and buffers every burst write.
// RULE_21 - Structs default to separate ports per member.
// RULE_22 - Packing concatenates members in order, first member at the LSB.
// RULE_23 - Reset returns the core to idle with ready, done and valids low.
package abi_pkg;
    localparam int ABI_DATA_W = 32;
    localparam int ABI_ARR_AW = 8;
    localparam int ABI_MEMBERS = 2;
    // Register byte offsets.
    localparam logic [7:0] ABI_OFS_CTRL = 8'h00;
    localparam logic [7:0] ABI_OFS_STATUS = 8'h04;
    localparam logic [7:0] ABI_OFS_RESULT = 8'h08;
    localparam logic [7:0] ABI_OFS_ARRLEN = 8'h0C;
    localparam logic [7:0] ABI_OFS_PMODE = 8'h10;
    // Control register fields.
    localparam int ABI_CTRL_START = 0;
    localparam int ABI_CTRL_MODE_LSB = 1;
    localparam int ABI_CTRL_MAP = 3;
    localparam int ABI_CTRL_SRC = 4;
    localparam int ABI_CTRL_PACK = 5;
    localparam int ABI_CTRL_CONT = 6;
    // Status register fields.
    localparam int ABI_STAT_DONE = 0;
    localparam int ABI_STAT_IDLE = 1;
    localparam int ABI_STAT_HALT = 2;
    localparam int ABI_STAT_BUSY = 3;
    // Values after reset.
    localparam logic [31:0] ABI_ARRLEN_RST = 32'h0000_0004;
    localparam logic [31:0] ABI_ZERO_RST = 32'h0000_0000;
    // Memory read latency in cycles.
    localparam int ABI_MEM_LAT = 1;

    typedef enum logic [1:0] {
        handshake_control_mode = 2'h0,
        chained_control_mode = 2'h1,
        no_control_mode = 2'h2
    } abi_ctrl_type;

    typedef enum logic [2:0] {
        plain_wire_mode = 3'h0,
        stable_wire_mode = 3'h1,
        valid_only_mode = 3'h2,
        ack_only_mode = 3'h3,
        full_handshake_mode = 3'h4
    } abi_pmode_type;

    typedef enum logic [3:0] {
        ABI_S_IDLE = 4'b0001,
        ABI_S_READ = 4'b0010,
        ABI_S_ARR = 4'b0100,
        ABI_S_HALT = 4'b1000
    } abi_state_type;
endpackage

// ===== logic/abi_port_in.sv
// Scalar input port with selectable wire protocol.
`timescale 1ns/1ps
module abi_port_in import abi_pkg::*; #(
    parameter int W = ABI_DATA_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Core side
    input wire abi_pmode_type mode,
    input wire logic req,
    output logic take,
    output logic [W-1:0] data_out,
    // Pin side
    input wire logic [W-1:0] data_in,
    input wire logic vld_in,
    output logic ack_out
);
    generate
        if (W < 1) begin : g_bad_w
            $error("abi_port_in: width must be positive");
        end
    endgenerate

    logic [W-1:0] stable_r;
    logic need_vld;

    assign need_vld = (mode == valid_only_mode) || (mode == full_handshake_mode);
    assign take = req && (!need_vld || vld_in); // see RULE_13
    // Stable inputs only move under reset, so the value seen there is kept.
    assign data_out = (mode == stable_wire_mode) ? stable_r : data_in; // see RULE_11

    always_ff @(posedge clk) begin
        if (rst) begin
            stable_r <= data_in; // see RULE_12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_out <= 1'b0;
        end else begin
            ack_out <= take && ((mode == ack_only_mode) || (mode == full_handshake_mode)); // see RULE_14
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_valid_only_no_ack;
        (mode == valid_only_mode) && $past(mode == valid_only_mode) |-> !ack_out;
    endproperty
    a_valid_only_no_ack: assert property (p_valid_only_no_ack) else $error("ack seen in valid-only mode"); // see RULE_14
endmodule

// ===== logic/abi_pack.sv
// Struct member output stage, separate or packed into one vector.
`timescale 1ns/1ps
module abi_pack import abi_pkg::*; #(
    parameter int W = ABI_DATA_W,
    parameter int N = ABI_MEMBERS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic pack_en,
    // Members in declaration order
    input wire logic [W-1:0] members [N],
    // Outputs
    output logic [W-1:0] sep_r [N],
    output logic [N*W-1:0] vec_r
);
    generate
        if (N < 1 || W < 1) begin : g_bad
            $error("abi_pack: need at least one member of positive width");
        end
    endgenerate

    for (genvar i = 0; i < N; i++) begin : g_m
        always_ff @(posedge clk) begin
            if (rst) begin
                sep_r[i] <= '0;
                vec_r[i*W +: W] <= '0;
            end else if (load) begin
                sep_r[i] <= pack_en ? '0 : members[i]; // see RULE_21
                vec_r[i*W +: W] <= pack_en ? members[i] : '0; // see RULE_22
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_first_at_lsb;
        $past(load && pack_en) |-> vec_r[W-1:0] == $past(members[0]) && vec_r[N*W-1 -: W] == $past(members[N-1]);
    endproperty
    a_first_at_lsb: assert property (p_first_at_lsb) else $error("packed member order wrong"); // see RULE_22
endmodule

// ===== logic/abi_core.sv
// Compute core with block-level control, port protocols and an AHB-Lite register slave.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module abi_core import abi_pkg::*; #(
    parameter int DATA_W = ABI_DATA_W,
    parameter int ARR_AW = ABI_ARR_AW
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Block-level control
    input wire logic go_in,
    input wire logic downstream_go_on,
    output logic inputs_taken,
    output logic finish_flag,
    output logic waiting_flag,
    output logic [DATA_W-1:0] result_out,
    // Scalar argument a, protocol chosen by register
    input wire logic [DATA_W-1:0] in1_data,
    input wire logic in1_vld,
    output logic in1_ack,
    // Scalar argument b, plain wire
    input wire logic [DATA_W-1:0] in2_data,
    // Read-write argument split into input and output with valid
    input wire logic [DATA_W-1:0] sum_i,
    output logic [DATA_W-1:0] sum_o,
    output logic sum_o_vld,
    // Array argument on a memory port
    output logic [ARR_AW-1:0] mem_addr,
    output logic mem_ce,
    output logic mem_we,
    output logic [DATA_W-1:0] mem_wdata,
    input wire logic [DATA_W-1:0] mem_rdata,
    // Array argument on a read-only FIFO port
    input wire logic [DATA_W-1:0] fifo_dout,
    input wire logic fifo_empty_n,
    output logic fifo_read,
    // Struct result, separate members or packed
    output logic [DATA_W-1:0] st_a_out,
    output logic [DATA_W-1:0] st_b_out,
    output logic [2*DATA_W-1:0] pack_out,
    output logic st_vld
);
    generate
        if (DATA_W < 1 || DATA_W > 32 || ARR_AW < 1 || ARR_AW > 16) begin : g_bad
            $error("abi_core: DATA_W must be 1..32 and ARR_AW 1..16");
        end
    endgenerate

    // Register state.
    abi_ctrl_type ctrl_mode_r;
    abi_pmode_type pmode_r;
    logic start_r, map_r, src_r, pack_r, cont_r, done_sticky_r;
    logic [ARR_AW-1:0] len_r;
    // Bus pipeline.
    logic bus_acc, bus_wr_r;
    logic [7:0] bus_addr_r;
    // Core datapath.
    abi_state_type state_r, state_nxt;
    logic [DATA_W-1:0] in1_r, in2_r, acc_r, in1_val;
    logic [ARR_AW-1:0] iss_r, got_r, got_nxt;
    logic rd_pend_r, consume, arr_done, in1_take, go_eff, cont_eff, vis, chain;
    logic [DATA_W-1:0] st_m [2];
    logic [DATA_W-1:0] st_sep [2];

    // Zero wait states: every transfer is answered OKAY in the cycle after its address phase.
    assign bus_acc = hsel && htrans[1] && hready;
    assign vis = (ctrl_mode_r != no_control_mode);
    assign chain = (ctrl_mode_r == chained_control_mode);
    // A core without block control runs back to back on its own.
    assign go_eff = !vis || (map_r ? start_r : go_in); // see RULE_05 see RULE_07 see RULE_08
    assign cont_eff = map_r ? cont_r : downstream_go_on; // see RULE_08
    assign consume = fifo_read && fifo_empty_n; // see RULE_09
    assign arr_done = (state_r == ABI_S_ARR) && (got_r == len_r);

    always_comb begin
        got_nxt = got_r;
        if ((src_r && consume) || (!src_r && rd_pend_r)) begin
            got_nxt = got_r + 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ABI_S_IDLE: if (go_eff) state_nxt = ABI_S_READ; // see RULE_01
            ABI_S_READ: if (in1_take) state_nxt = ABI_S_ARR;
            ABI_S_ARR: if (arr_done) state_nxt = (chain && !cont_eff) ? ABI_S_HALT : ABI_S_IDLE; // see RULE_06
            ABI_S_HALT: if (cont_eff) state_nxt = ABI_S_IDLE; // see RULE_06
            default: state_nxt = ABI_S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ABI_S_IDLE; // see RULE_23
        end else begin
            state_r <= state_nxt;
        end
    end

    abi_port_in #(.W(DATA_W)) u_in1 (
        .clk(clk),
        .rst(rst),
        .mode(pmode_r),
        .req(state_r == ABI_S_READ),
        .take(in1_take),
        .data_out(in1_val),
        .data_in(in1_data),
        .vld_in(in1_vld),
        .ack_out(in1_ack)
    );

    // Scalar capture and the split read-write output.
    always_ff @(posedge clk) begin
        if (rst) begin
            in1_r <= '0;
            in2_r <= '0;
            sum_o <= '0;
            sum_o_vld <= 1'b0; // see RULE_23
        end else begin
            sum_o_vld <= in1_take; // see RULE_15
            if (in1_take) begin
                in1_r <= in1_val;
                in2_r <= in2_data; // see RULE_11
                sum_o <= in1_val + in2_data + sum_i; // see RULE_15
            end
        end
    end

    // Array walk: addresses rise by one, so a FIFO source sees the same order.
    always_ff @(posedge clk) begin
        if (rst) begin
            iss_r <= '0;
            got_r <= '0;
            acc_r <= '0;
            rd_pend_r <= 1'b0;
            mem_ce <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            fifo_read <= 1'b0;
        end else begin
            mem_ce <= 1'b0;
            mem_we <= 1'b0;
            // Read data stands one cycle after the memory samples the enable, so the pending flag trails it.
            rd_pend_r <= mem_ce && !mem_we;
            fifo_read <= src_r && (state_nxt == ABI_S_ARR) && (got_nxt < len_r) && !in1_take; // see RULE_19
            if (in1_take) begin
                iss_r <= '0;
                got_r <= '0;
                acc_r <= '0;
            end else if (state_r == ABI_S_ARR) begin
                got_r <= got_nxt;
                if (src_r && consume) begin
                    acc_r <= acc_r + fifo_dout;
                end
                if (!src_r && rd_pend_r) begin
                    acc_r <= acc_r + mem_rdata;
                end
                if (!src_r && iss_r < len_r) begin
                    mem_ce <= 1'b1; // see RULE_17 see RULE_18
                    mem_addr <= iss_r; // see RULE_16
                    iss_r <= iss_r + 1'b1;
                end
                // The result lands in the word just past the array.
                if (!src_r && arr_done) begin
                    mem_ce <= 1'b1;
                    mem_we <= 1'b1; // see RULE_17
                    mem_addr <= len_r;
                    mem_wdata <= in1_r + in2_r + acc_r;
                end
            end
        end
    end

    // Block-level outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            waiting_flag <= 1'b1; // see RULE_23
            inputs_taken <= 1'b0;
            finish_flag <= 1'b0;
            result_out <= '0;
        end else begin
            waiting_flag <= vis && (state_nxt == ABI_S_IDLE); // see RULE_04 see RULE_01
            inputs_taken <= vis && arr_done; // see RULE_02
            finish_flag <= vis && arr_done; // see RULE_03
            if (arr_done) begin
                result_out <= in1_r + in2_r + acc_r; // see RULE_03
            end
        end
    end

    assign st_m[0] = in1_r;
    assign st_m[1] = in2_r;

    abi_pack #(.W(DATA_W), .N(2)) u_pack (
        .clk(clk),
        .rst(rst),
        .load(arr_done),
        .pack_en(pack_r),
        .members(st_m),
        .sep_r(st_sep),
        .vec_r(pack_out)
    );
    assign st_a_out = st_sep[0];
    assign st_b_out = st_sep[1];

    always_ff @(posedge clk) begin
        if (rst) begin
            st_vld <= 1'b0;
        end else begin
            st_vld <= arr_done;
        end
    end

    // AHB-Lite address phase capture and read data.
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_wr_r <= 1'b0;
            bus_addr_r <= 8'h00;
            hrdata <= ABI_ZERO_RST;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            bus_wr_r <= bus_acc && hwrite;
            if (bus_acc) begin
                bus_addr_r <= haddr[7:0];
            end
            hrdata <= ABI_ZERO_RST;
            if (bus_acc && !hwrite) begin
                unique case (haddr[7:0])
                    ABI_OFS_CTRL: hrdata <= {25'h000_0000, cont_r, pack_r, src_r, map_r, ctrl_mode_r, start_r};
                    ABI_OFS_STATUS: hrdata <= {28'h000_0000, state_r != ABI_S_IDLE, state_r == ABI_S_HALT,
                        waiting_flag, done_sticky_r}; // see RULE_08
                    ABI_OFS_RESULT: hrdata <= 32'(result_out); // see RULE_10
                    ABI_OFS_ARRLEN: hrdata <= 32'(len_r);
                    ABI_OFS_PMODE: hrdata <= {29'h0000_0000, pmode_r};
                    default: hrdata <= ABI_ZERO_RST;
                endcase
            end
        end
    end

    // Control register writes; a start request written in the cycle it is taken stays set.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_mode_r <= handshake_control_mode; // see RULE_05
            start_r <= 1'b0;
            map_r <= 1'b0;
            src_r <= 1'b0;
            pack_r <= 1'b0;
            cont_r <= 1'b0;
            len_r <= ARR_AW'(ABI_ARRLEN_RST);
            pmode_r <= plain_wire_mode; // see RULE_11
        end else begin
            if (state_r == ABI_S_IDLE && go_eff) begin
                start_r <= 1'b0;
            end
            if (bus_wr_r && bus_addr_r == ABI_OFS_CTRL) begin
                start_r <= hwdata[ABI_CTRL_START]; // see RULE_08
                ctrl_mode_r <= abi_ctrl_type'(hwdata[ABI_CTRL_MODE_LSB +: 2]);
                map_r <= hwdata[ABI_CTRL_MAP];
                src_r <= hwdata[ABI_CTRL_SRC];
                pack_r <= hwdata[ABI_CTRL_PACK];
                cont_r <= hwdata[ABI_CTRL_CONT];
            end
            if (bus_wr_r && bus_addr_r == ABI_OFS_ARRLEN) begin
                len_r <= hwdata[ARR_AW-1:0];
            end
            if (bus_wr_r && bus_addr_r == ABI_OFS_PMODE) begin
                pmode_r <= abi_pmode_type'(hwdata[2:0]);
            end
        end
    end

    // Done is sticky until status is read; a completion in the read cycle wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            done_sticky_r <= 1'b0;
        end else if (arr_done) begin
            done_sticky_r <= 1'b1; // see RULE_08
        end else if (bus_acc && !hwrite && haddr[7:0] == ABI_OFS_STATUS) begin
            done_sticky_r <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take;
        in1_take && (pmode_r == full_handshake_mode);
    endsequence
    sequence s_ack;
        in1_ack ##1 !in1_ack;
    endsequence

    property p_reset_idle;
        @(posedge clk) disable iff (1'b0) rst |=> waiting_flag && !finish_flag && !inputs_taken && !sum_o_vld && !st_vld;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset did not return to idle"); // see RULE_23
    property p_busy_not_idle;
        (state_r == ABI_S_READ || state_r == ABI_S_ARR) |-> !waiting_flag;
    endproperty
    a_busy_not_idle: assert property (p_busy_not_idle) else $error("idle high during transaction"); // see RULE_01
    property p_ready_with_done;
        finish_flag |-> inputs_taken && result_out == in1_r + in2_r + acc_r;
    endproperty
    a_ready_with_done: assert property (p_ready_with_done) else $error("done without ready or bad result"); // see RULE_02
    property p_done_then_idle;
        finish_flag && !chain && $past(!chain) |-> waiting_flag ##1 (waiting_flag || !$past(go_eff));
    endproperty
    a_done_then_idle: assert property (p_done_then_idle) else $error("idle not held after completion"); // see RULE_04
    property p_halt_hold;
        state_r == ABI_S_HALT && !cont_eff |=> state_r == ABI_S_HALT && !waiting_flag;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("left halt without continue"); // see RULE_06
    property p_none_silent;
        !vis && $past(!vis) |-> !waiting_flag && !finish_flag && !inputs_taken;
    endproperty
    a_none_silent: assert property (p_none_silent) else $error("control activity in no-control mode"); // see RULE_07
    property p_map_ignores_pin;
        state_r == ABI_S_IDLE && map_r && vis && !start_r |=> state_r == ABI_S_IDLE;
    endproperty
    a_map_ignores_pin: assert property (p_map_ignores_pin) else $error("pin start used in mapped mode"); // see RULE_08
    property p_full_ack;
        s_take |=> s_ack;
    endproperty
    a_full_ack: assert property (p_full_ack) else $error("full handshake ack missing"); // see RULE_13
    property p_split_out;
        in1_take |=> sum_o_vld && sum_o == $past(in1_val) + $past(in2_data) + $past(sum_i);
    endproperty
    a_split_out: assert property (p_split_out) else $error("split output wrong"); // see RULE_15
    property p_seq_addr;
        mem_ce && $past(mem_ce) |-> mem_addr == $past(mem_addr) + 1'b1;
    endproperty
    a_seq_addr: assert property (p_seq_addr) else $error("memory access not sequential"); // see RULE_16
    property p_one_source;
        !(mem_ce && fifo_read);
    endproperty
    a_one_source: assert property (p_one_source) else $error("fifo and memory active together"); // see RULE_19
endmodule

// ===== tb/abi_far_model.sv
// Memory and FIFO source standing at the far side of the core's array ports.
`timescale 1ns/1ps
module abi_far_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Memory port
    input wire logic [7:0] mem_addr,
    input wire logic mem_ce,
    output logic [31:0] mem_rdata,
    // FIFO port
    input wire logic fifo_read,
    input wire logic stall,
    output logic [31:0] fifo_dout,
    output logic fifo_empty_n
);
    logic [31:0] cnt_r;
    // Writes are absorbed at once and never push back on the core.
    // Data comes one cycle after the read; otherwise the bus toggles so stale data never passes as valid.
    always_ff @(posedge clk) begin
        mem_rdata <= mem_ce ? 32'h0000_1000 + 32'(mem_addr) : ~mem_rdata;
    end
    // One word leaves at each edge where it is both offered and read.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0000_0000;
        end else if (fifo_read && fifo_empty_n) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end
    assign fifo_empty_n = !stall;
    assign fifo_dout = fifo_empty_n ? 32'h0000_2000 + cnt_r : ~cnt_r;
endmodule

// ===== tb/abi_core_tb.sv
// Self-checking bench for the accelerator block interface core.
`timescale 1ns/1ps
module abi_core_tb;
    import abi_pkg::*;
    typedef struct packed {
        logic [31:0] res;
        logic [31:0] a;
        logic [31:0] b;
        logic pk;
        logic wt;
        logic sr;
    } abi_exp_type;
    // Value held on the argument pin while reset is applied.
    localparam logic [31:0] STABLE_A = 32'h0000_0011;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, go_in, downstream_go_on, inputs_taken, finish_flag;
    logic waiting_flag, in1_vld, in1_ack, sum_o_vld, mem_ce, mem_we, fifo_empty_n, fifo_read, st_vld, stall;
    logic [31:0] haddr, hwdata, hrdata, result_out, in1_data, in2_data, sum_i, sum_o, mem_wdata, mem_rdata;
    logic [31:0] fifo_dout, st_a_out, st_b_out, fifo_base, q;
    logic [63:0] pack_out;
    logic [7:0] mem_addr;
    logic [2:0] hsize;
    logic [1:0] htrans;
    int mismatches, num_checks, seed, n;
    abi_exp_type exp_q[$];
    abi_core dut (.hready(hreadyout), .*);
    abi_far_model far (.*);
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic limit(input int k, input int lim);
        if (k >= lim) begin
            check("wait bound", 64'h0, 64'h1);
            finish_test();
        end
    endtask
    task automatic edge_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'h1 && k < 50);
        limit(k, 50);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'h1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        edge_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_ready();
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        check("hrdata", {31'h0, 1'h0, e}, {31'h0, hresp, r});
    endtask
    // Bit 6 of ctrl drives the continue pin as well as the register field.
    task automatic run(input logic [6:0] ctrl, input logic [2:0] pm, input logic [7:0] len);
        abi_exp_type e;
        logic [31:0] s;
        int acks, vlds;
        e.a = $random(seed);
        e.b = $random(seed);
        s = $random(seed);
        if (pm == stable_wire_mode) e.a = STABLE_A;
        in1_data <= e.a;
        in2_data <= e.b;
        sum_i <= s;
        downstream_go_on <= ctrl[6];
        bus(1'h1, ABI_OFS_PMODE, {29'h0, pm}, q);
        bus(1'h1, ABI_OFS_ARRLEN, {24'h0, len}, q);
        bus(1'h1, ABI_OFS_CTRL, {25'h0, ctrl}, q);
        e.res = e.a + e.b;
        for (int i = 0; i < len; i++) begin
            e.res += ctrl[4] ? 32'h0000_2000 + fifo_base + 32'(i) : 32'h0000_1000 + 32'(i);
        end
        if (ctrl[4]) fifo_base += 32'(len);
        e.pk = ctrl[5];
        e.sr = ctrl[4];
        e.wt = ctrl[2:1] != 2'h1 || ctrl[6];
        exp_q.push_back(e);
        if (ctrl[3]) bus(1'h1, ABI_OFS_CTRL, {25'h0, ctrl | 7'h01}, q);
        else go_in <= 1'h1;
        n = 0;
        acks = 0;
        vlds = 0;
        do begin
            @(posedge clk);
            n++;
            if (waiting_flag === 1'h0) go_in <= 1'h0;
            in1_vld <= n > 3;
            stall <= 1'($random(seed));
            if (in1_ack === 1'h1) acks++;
            if (sum_o_vld === 1'h1) begin
                vlds++;
                check("sum_o", {32'h0, e.a + e.b + s}, {32'h0, sum_o});
            end
        end while (finish_flag !== 1'h1 && n < 300);
        limit(n, 300);
        in1_vld <= 1'h0;
        check("in1_ack pulses", 64'(pm >= 3'h3), 64'(acks));
        check("sum_o_vld pulses", 64'h1, 64'(vlds));
    endtask
    always @(posedge clk) begin
        abi_exp_type e;
        if (finish_flag === 1'h1 && exp_q.size() == 0) begin
            check("finish_flag", 64'h0, 64'h1);
        end else if (finish_flag === 1'h1) begin
            e = exp_q.pop_front();
            check("result_out", {32'h0, e.res}, {32'h0, result_out});
            check("inputs_taken st_vld", 64'h3, {62'h0, inputs_taken, st_vld});
            if (e.wt) check("waiting_flag", 64'h1, 64'(waiting_flag));
            check("pack_out", e.pk ? {e.b, e.a} : 64'h0, pack_out);
            check("st members", e.pk ? 64'h0 : {e.b, e.a}, {st_b_out, st_a_out});
            check("mem write", e.sr ? 64'h0 : {31'h0, 1'h1, e.res}, {31'h0, mem_we, mem_we ? mem_wdata : 32'h0});
        end
    end
    initial begin
        seed = 82;
        rst = 1'h1;
        {hsel, hwrite, go_in, downstream_go_on, in1_vld, stall} = 6'h00;
        {haddr, hwdata, in2_data, sum_i, fifo_base} = '0;
        htrans = 2'h0;
        hsize = 3'h2;
        in1_data = STABLE_A;
        repeat (12) @(posedge clk);
        check("waiting_flag", 64'h1, 64'(waiting_flag));
        check("pulses", 64'h0, 64'({finish_flag, inputs_taken, sum_o_vld, st_vld}));
        rst <= 1'h0;
        @(posedge clk);
        rd(ABI_OFS_ARRLEN, ABI_ARRLEN_RST);
        rd(ABI_OFS_STATUS, 32'h0000_0002);
        rd(8'h40, ABI_ZERO_RST);
        for (int i = 0; i < 5; i++) begin
            run(7'h00, 3'(i), 8'(i));
        end
        run(7'h30, full_handshake_mode, 8'h05);
        run(7'h02, plain_wire_mode, 8'h02);
        // A held start must not launch anything while the core is halted.
        go_in <= 1'h1;
        repeat (6) begin
            @(posedge clk);
            check("waiting_flag", 64'h0, 64'(waiting_flag));
        end
        go_in <= 1'h0;
        downstream_go_on <= 1'h1;
        n = 0;
        while (waiting_flag !== 1'h1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        limit(n, 20);
        run(7'h42, valid_only_mode, 8'h03);
        run(7'h28, ack_only_mode, 8'h01);
        rd(ABI_OFS_STATUS, 32'h0000_0003);
        rd(ABI_OFS_STATUS, 32'h0000_0002);
        bus(1'h1, ABI_OFS_CTRL, 32'h0000_0004, q);
        go_in <= 1'h1;
        // Control outputs are registered, so the new mode shows one edge after the write.
        @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            check("control outputs", 64'h0, 64'({finish_flag, inputs_taken, waiting_flag}));
        end
        finish_test();
    end
endmodule
